// *** common/pwm_pkg.sv ***
// package: register map, field layout, mode codes and timing for the dual pwm block
// assumes: a 32-bit axi4-lite register bus and one 40 MHz system clock
package pwm_pkg;
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
  localparam logic [ADDR_W-1:0] A_LOW_OFS = 5'h04;
  localparam logic [ADDR_W-1:0] A_HIGH_OFS = 5'h08;
  localparam logic [ADDR_W-1:0] B_LOW_OFS = 5'h0C;
  localparam logic [ADDR_W-1:0] B_HIGH_OFS = 5'h10;
  localparam logic [ADDR_W-1:0] STAT_OFS = 5'h14;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int MODE_LSB = 4;
  localparam int PRESC_LSB = 2;
  localparam int CSEL_LSB = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_SINGLE = 3'h1;
  localparam logic [2:0] MODE_TWIN8 = 3'h2;
  localparam logic [2:0] MODE_TWIN16 = 3'h3;
  localparam logic [2:0] MODE_NRZ = 3'h4;
  localparam logic [2:0] MODE_DUAL8 = 3'h5;
  localparam logic [2:0] MODE_RZ = 3'h6;
  localparam logic [7:0] PRESC_DIV1 = 8'h00;
  localparam logic [7:0] PRESC_DIV4 = 8'h03;
  localparam logic [7:0] PRESC_DIV16 = 8'h0F;
  localparam logic [7:0] PRESC_DIV64 = 8'h3F;
  localparam int RZ_DIV_REC = 4;
  typedef enum logic [1:0] {W_IDLE, W_RESP} wr_state_e;
endpackage

// *** src/dual_pwm_sigma_delta_dac.sv ***
// file: dual pwm and sigma-delta dac with an axi4-lite register file
// assumes: ext_clk_pin is asynchronous; divided core clock sources come as enables
//
// Behaviour
// - mode 0 releases both pins
// - mode 1 period from channel b word
// - mode 1 duty from channel a word
// - mode 2 shared 8-bit period b low
// - mode 2 first output low at a low
// - mode 2 second high at b high, low a high
// - mode 3 counter runs full 16 bits
// - mode 3 first high below a word
// - mode 3 second high below b word
// - mode 3 both rise at rollover
// - mode 4 outputs update every pwm clock
// - mode 4 high for word count cycles
// - cleared low bits give faster repetition
// - mode 5 own 8-bit periods from b
// - mode 5 duties from a low/high
// - mode 5 shares clock and prescaler
// - mode 6 high only first half clock, whole clock at divide by 1
// - three-bit mode field selects mode
// - control write resets the counter
// - low byte held, high commits next cycle
// - prescaler divides by 1,4,16,64
//
// Local design decisions: the AXI4-Lite register port and the register addresses.
`timescale 1ns/100ps
module dual_pwm_sigma_delta_dac
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic osc_div_tick,
  input wire logic osc_div15_tick,
  input wire logic ext_clk_pin,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic first_output_pin,
  output logic first_output_oe,
  output logic second_output_pin,
  output logic second_output_oe
);
  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [7:0] modulator_control_reg, next_ctrl;
  logic [7:0] chan_a_low_byte, next_a_low;
  logic [7:0] chan_a_high_byte, next_a_high;
  logic [7:0] chan_b_low_byte, next_b_low;
  logic [7:0] chan_b_high_byte, next_b_high;
  logic [7:0] a_hold, next_a_hold;
  logic [7:0] b_hold, next_b_hold;
  logic [15:0] chan_a_word, next_a_word;
  logic [15:0] chan_b_word, next_b_word;
  logic [1:0] wr_pend, next_wr_pend;
  logic aw_got, next_aw_got;
  logic w_got, next_w_got;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  wr_state_e wr_state, next_wr_state;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic ctrl_write;
  logic [2:0] mode;
  logic [1:0] presc;
  logic [1:0] csel;
  logic [15:0] count, next_count;
  logic period_end;
  assign mode = modulator_control_reg[MODE_LSB +: 3];
  assign presc = modulator_control_reg[PRESC_LSB +: 2];
  assign csel = modulator_control_reg[CSEL_LSB +: 2];

  // ----------------------------------------------------------------
  // axi4-lite write
  // ----------------------------------------------------------------
  assign s_axi_awready = (wr_state == W_IDLE) && !aw_got;
  assign s_axi_wready = (wr_state == W_IDLE) && !w_got;
  // built from present state and handshakes only, so it cannot loop through next_ values
  assign do_write = (wr_state == W_IDLE) && (aw_got || (s_axi_awvalid && s_axi_awready))
    && (w_got || (s_axi_wvalid && s_axi_wready));
  assign ctrl_write = do_write && (next_aw_addr == CTRL_OFS) && next_w_strb[0];
  always_comb begin
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_wr_state = wr_state;
    next_bresp = s_axi_bresp;
    next_ctrl = modulator_control_reg;
    next_a_low = chan_a_low_byte;
    next_a_high = chan_a_high_byte;
    next_b_low = chan_b_low_byte;
    next_b_high = chan_b_high_byte;
    next_a_hold = a_hold;
    next_b_hold = b_hold;
    next_wr_pend = wr_pend;
    // a commit landing at a period end stays pending: set wins over clear
    if (period_end) begin
      next_wr_pend = 2'h0;
    end
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_got = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_got = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_got = 1'b0;
      next_w_got = 1'b0;
      next_wr_state = W_RESP;
      next_bresp = RESP_OKAY;
      if (next_w_strb[0]) begin
        case (next_aw_addr)
          CTRL_OFS: next_ctrl = next_w_data[7:0];
          A_LOW_OFS: next_a_hold = next_w_data[7:0];
          B_LOW_OFS: next_b_hold = next_w_data[7:0];
          A_HIGH_OFS: begin
            next_a_high = next_w_data[7:0];
            next_a_low = a_hold;
            next_wr_pend[0] = 1'b1;
          end
          B_HIGH_OFS: begin
            next_b_high = next_w_data[7:0];
            next_b_low = b_hold;
            next_wr_pend[1] = 1'b1;
          end
          STAT_OFS: next_bresp = RESP_OKAY;
          default: next_bresp = RESP_SLVERR;
        endcase
      end else if (next_aw_addr > STAT_OFS || next_aw_addr[1:0] != 2'h0) begin
        next_bresp = RESP_SLVERR;
      end
    end else if (wr_state == W_RESP && s_axi_bready) begin
      next_wr_state = W_IDLE;
    end
  end
  assign s_axi_bvalid = (wr_state == W_RESP);

  // ----------------------------------------------------------------
  // axi4-lite read
  // ----------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFS: next_rdata = {24'h000000, modulator_control_reg};
        A_LOW_OFS: next_rdata = {24'h000000, chan_a_low_byte};
        A_HIGH_OFS: next_rdata = {24'h000000, chan_a_high_byte};
        B_LOW_OFS: next_rdata = {24'h000000, chan_b_low_byte};
        B_HIGH_OFS: next_rdata = {24'h000000, chan_b_high_byte};
        STAT_OFS: next_rdata = {12'h000, wr_pend, first_output_pin, second_output_pin, count};
        default: begin
          next_rdata = 32'h00000000;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // clock source and prescaler
  // ----------------------------------------------------------------
  logic ext_s1, ext_s2, ext_s3;
  logic src_tick;
  logic step;
  logic half;
  always_comb begin
    case (csel)
      2'h0: src_tick = osc_div15_tick;
      2'h1: src_tick = osc_div_tick;
      2'h2: src_tick = ext_s2 && !ext_s3;
      default: src_tick = 1'b1;
    endcase
  end
  pwm_div u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(ctrl_write),
    .tick_in(src_tick),
    .presc(presc),
    .step(step),
    .half(half)
  );

  // ----------------------------------------------------------------
  // counters and waveform
  // ----------------------------------------------------------------
  logic [7:0] count_b, next_count_b;
  logic out_a, next_out_a;
  logic out_b, next_out_b;
  logic [15:0] period_top;
  logic sd_a, sd_b;
  always_comb begin
    case (mode)
      MODE_SINGLE: period_top = chan_b_word - 16'h0001;
      MODE_TWIN8, MODE_DUAL8: period_top = {8'h00, chan_b_low_byte};
      default: period_top = 16'hFFFF;
    endcase
  end
  assign period_end = step && (count >= period_top);
  always_comb begin
    next_count = count;
    next_count_b = count_b;
    next_out_a = out_a;
    next_out_b = out_b;
    next_a_word = chan_a_word;
    next_b_word = chan_b_word;
    // a disabled modulator holds its counters at zero
    if (ctrl_write || (mode == MODE_OFF)) begin
      next_count = 16'h0000;
      next_count_b = 8'h00;
      next_out_a = 1'b0;
      next_out_b = 1'b0;
    end else if (step) begin
      next_count = period_end ? 16'h0000 : count + 16'h0001;
      next_count_b = (count_b >= chan_b_high_byte) ? 8'h00 : count_b + 8'h01;
      // outputs follow the counter value one step late
      case (mode)
        MODE_SINGLE: next_out_a = (count < chan_a_word);
        MODE_TWIN8: begin
          if (count[7:0] == 8'h00) next_out_a = 1'b1;
          if (count[7:0] == chan_a_low_byte) next_out_a = 1'b0;
          if (count[7:0] == chan_b_high_byte) next_out_b = 1'b1;
          if (count[7:0] == chan_a_high_byte) next_out_b = 1'b0;
        end
        MODE_TWIN16: begin
          next_out_a = (count < chan_a_word);
          next_out_b = (count < chan_b_word);
        end
        MODE_DUAL8: begin
          next_out_a = (count[7:0] < chan_a_low_byte);
          next_out_b = (count_b < chan_a_high_byte);
        end
        default: begin
          next_out_a = 1'b0;
          next_out_b = 1'b0;
        end
      endcase
    end
    if (period_end || (mode == MODE_NRZ) || (mode == MODE_RZ) || ctrl_write) begin
      next_a_word = {chan_a_high_byte, chan_a_low_byte};
      next_b_word = {chan_b_high_byte, chan_b_low_byte};
    end
  end
  // sigma-delta: low bits left at zero make the carry pattern repeat sooner
  sd_chan #(.W(16)) u_sd_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(ctrl_write),
    .step(step),
    .duty(chan_a_word),
    .bit_out(sd_a)
  );
  sd_chan #(.W(16)) u_sd_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(ctrl_write),
    .step(step),
    .duty(chan_b_word),
    .bit_out(sd_b)
  );
  always_comb begin
    first_output_oe = 1'b1;
    second_output_oe = 1'b1;
    case (mode)
      MODE_OFF: begin
        first_output_oe = 1'b0;
        second_output_oe = 1'b0;
        first_output_pin = 1'b0;
        second_output_pin = 1'b0;
      end
      MODE_SINGLE: begin
        first_output_oe = 1'b0;
        first_output_pin = 1'b0;
        second_output_pin = out_a;
      end
      MODE_NRZ: begin
        first_output_pin = sd_a;
        second_output_pin = sd_b;
      end
      MODE_RZ: begin
        first_output_pin = sd_a && !half;
        second_output_pin = sd_b && !half;
      end
      MODE_TWIN8, MODE_TWIN16, MODE_DUAL8: begin
        first_output_pin = out_a;
        second_output_pin = out_b;
      end
      default: begin
        first_output_oe = 1'b0;
        second_output_oe = 1'b0;
        first_output_pin = 1'b0;
        second_output_pin = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      modulator_control_reg <= CTRL_RESET;
      chan_a_low_byte <= 8'h00;
      chan_a_high_byte <= 8'h00;
      chan_b_low_byte <= 8'h00;
      chan_b_high_byte <= 8'h00;
      a_hold <= 8'h00;
      b_hold <= 8'h00;
      chan_a_word <= 16'h0000;
      chan_b_word <= 16'h0000;
      wr_pend <= 2'h0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      wr_state <= W_IDLE;
      s_axi_bresp <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
      count <= 16'h0000;
      count_b <= 8'h00;
      out_a <= 1'b0;
      out_b <= 1'b0;
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
    end else begin
      modulator_control_reg <= next_ctrl;
      chan_a_low_byte <= next_a_low;
      chan_a_high_byte <= next_a_high;
      chan_b_low_byte <= next_b_low;
      chan_b_high_byte <= next_b_high;
      a_hold <= next_a_hold;
      b_hold <= next_b_hold;
      chan_a_word <= next_a_word;
      chan_b_word <= next_b_word;
      wr_pend <= next_wr_pend;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      wr_state <= next_wr_state;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      count <= next_count;
      count_b <= next_count_b;
      out_a <= next_out_a;
      out_b <= next_out_b;
      ext_s1 <= ext_clk_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
    end
  end
endmodule

// *** src/pwm_div.sv ***
// file: prescaler turning the selected pwm clock into a counter step enable
// assumes: tick_in is a one-cycle enable on sys_clk
`timescale 1ns/100ps
module pwm_div
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] presc,
  output logic step,
  output logic half
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] limit;
  always_comb begin
    case (presc)
      2'h0: limit = PRESC_DIV1;
      2'h1: limit = PRESC_DIV4;
      2'h2: limit = PRESC_DIV16;
      default: limit = PRESC_DIV64;
    endcase
  end
  // divide by 1, 4, 16 or 64
  assign step = tick_in && (cnt >= limit);
  // second half of a counter step, used for return-to-zero shaping
  assign half = (limit == PRESC_DIV1) ? 1'b0 : (cnt > (limit >> 1));
  always_comb begin
    next_cnt = cnt;
    if (clear) begin
      next_cnt = 8'h00;
    end else if (step) begin
      next_cnt = 8'h00;
    end else if (tick_in) begin
      next_cnt = cnt + 8'h01;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt <= 8'h00;
    end else begin
      cnt <= next_cnt;
    end
  end
endmodule

// *** src/sd_chan.sv ***
// file: one sigma-delta channel, a 16-bit accumulator with carry out
// assumes: step is a one-cycle enable; clear restarts the accumulator
`timescale 1ns/100ps
module sd_chan #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic step,
  input wire logic [W-1:0] duty,
  output logic bit_out
);
  logic [W-1:0] acc;
  logic [W-1:0] next_acc;
  logic next_bit;
  logic [W:0] sum;
  always_comb begin
    sum = {1'b0, acc} + {1'b0, duty};
    next_acc = acc;
    next_bit = bit_out;
    if (clear) begin
      next_acc = '0;
      next_bit = 1'b0;
    end else if (step) begin
      next_acc = sum[W-1:0];
      next_bit = sum[W];
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc <= '0;
      bit_out <= 1'b0;
    end else begin
      acc <= next_acc;
      bit_out <= next_bit;
    end
  end
endmodule

// *** tb/dual_pwm_sigma_delta_dac_checker.sv ***
// checker: bus handshakes and pin release against the mode field
// assumes: address and data of a write are offered together
`timescale 1ns/100ps
module dual_pwm_sigma_delta_dac_checker
  import pwm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic first_output_oe,
  input wire logic second_output_oe
);
  // ----
  // mode shadow
  // ----
  logic [2:0] mode;
  logic [2:0] next_mode;
  logic wr_go;
  assign wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  always_comb begin
    next_mode = mode;
    if (wr_go && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]) next_mode = s_axi_wdata[6:4];
  end
  always_ff @(posedge sys_clk) begin
    if (rst) mode <= MODE_OFF;
    else mode <= next_mode;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----
  // assertions
  // ----
  chk_b_answer: assert property (wr_go |=> s_axi_bvalid)
    else $error("write response missing");
  chk_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data missing");
  chk_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  chk_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > STAT_OFS
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read");
  chk_off_release: assert property (mode == $past(mode) && (mode == MODE_OFF || mode == 3'h7)
    |-> !first_output_oe && !second_output_oe) else $error("pins not released");
  chk_single_pin: assert property (mode == $past(mode) && mode == MODE_SINGLE
    |-> !first_output_oe && second_output_oe) else $error("single mode pins wrong");
  chk_dual_pins: assert property (mode == $past(mode) && mode >= MODE_TWIN8
    && mode <= MODE_RZ |-> first_output_oe && second_output_oe) else $error("pins not driven");
endmodule

bind dual_pwm_sigma_delta_dac dual_pwm_sigma_delta_dac_checker i_dual_pwm_sigma_delta_dac_checker (
  .sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .first_output_oe(first_output_oe), .second_output_oe(second_output_oe)
);

// *** tb/pwm_load.sv ***
// model: load on one output pin, counts cycles the pad sits high
// assumes: a released pin is pulled down
`timescale 1ns/100ps
module pwm_load (
  input wire logic sys_clk,
  input wire logic clr,
  input wire logic pin,
  input wire logic oe,
  output logic [31:0] high_cnt
);
  logic pad;
  assign pad = oe ? pin : 1'h0;
  always @(posedge sys_clk) begin
    if (clr) high_cnt <= 32'h0;
    else high_cnt <= high_cnt + {31'h0, pad};
  end
endmodule

// *** tb/tb_dual_pwm_sigma_delta_dac.sv ***
// testbench: register access and per-mode high counts of both pins
// assumes: sys_clk selected as pwm source for waveform checks
`timescale 1ns/100ps
module tb_dual_pwm_sigma_delta_dac;
  import pwm_pkg::*;
  logic sys_clk = 1'h0, rst = 1'h1, osc_div_tick = 1'h0, osc_div15_tick = 1'h0;
  logic ext_clk_pin = 1'h0, cnt_clr = 1'h1;
  logic [ADDR_W-1:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, cnt1, cnt2, rd;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic first_output_pin, first_output_oe, second_output_pin, second_output_oe;
  int n_fail = 0, n_tests = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  dual_pwm_sigma_delta_dac i_dual_pwm_sigma_delta_dac (.sys_clk, .rst, .osc_div_tick,
    .osc_div15_tick, .ext_clk_pin, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .first_output_pin, .first_output_oe, .second_output_pin,
    .second_output_oe);
  pwm_load i_pwm_load_first (.sys_clk(sys_clk), .clr(cnt_clr), .pin(first_output_pin),
    .oe(first_output_oe), .high_cnt(cnt1));
  pwm_load i_pwm_load_second (.sys_clk(sys_clk), .clr(cnt_clr), .pin(second_output_pin),
    .oe(second_output_oe), .high_cnt(cnt2));
  // ----
  // tasks
  // ----
  task automatic give_verdict();
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'($urandom);
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (!s_axi_bready && ($urandom % 3 == 0)) s_axi_bready <= 1'h1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
    r = s_axi_bresp;
  endtask
  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'($urandom);
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (!s_axi_rready && ($urandom % 3 == 0)) s_axi_rready <= 1'h1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
    rd = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic load(input logic [15:0] a, input logic [15:0] b);
    wr(A_LOW_OFS, {24'h0, a[7:0]});
    wr(A_HIGH_OFS, {24'h0, a[15:8]});
    wr(B_LOW_OFS, {24'h0, b[7:0]});
    wr(B_HIGH_OFS, {24'h0, b[15:8]});
  endtask
  task automatic run(input int settle, input int n);
    repeat (settle) @(posedge sys_clk);
    cnt_clr <= 1'h1;
    @(posedge sys_clk);
    cnt_clr <= 1'h0;
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    osc_div_tick <= ($urandom % 4) == 0;
    osc_div15_tick <= ($urandom % 15) == 0;
    ext_clk_pin <= 1'($urandom);
    if (cycles == 60000) begin
      n_fail++;
      give_verdict();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    logic [15:0] a, b;
    int dv;
    logic [1:0] pc;
    void'($urandom(32'h986c));
    repeat (4) @(posedge sys_clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rd_reg(5'(i * 4));
      check("reset value", 32'h0, rd);
    end
    check("oe after reset", 32'h0, {30'h0, first_output_oe, second_output_oe});
    rd_reg(5'h18);
    check("unmapped read", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(5'h1C, 32'h5);
    check("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    for (int m = 0; m < 8; m++) begin
      a = 16'($urandom);
      wr(CTRL_OFS, {24'h0, a[7], 3'(m), a[3:0]});
      rd_reg(CTRL_OFS);
      check("control readback", {24'h0, a[7], 3'(m), a[3:0]}, rd);
    end
    wr(CTRL_OFS, 32'h43);
    wr(A_LOW_OFS, 32'h5A);
    rd_reg(A_LOW_OFS);
    check("low byte held", 32'h0, rd);
    wr(A_HIGH_OFS, 32'hC3);
    rd_reg(A_LOW_OFS);
    check("low byte committed", 32'h5A, rd);
    a = 16'(16 + $urandom % 400);
    b = 16'(16 + $urandom % 400);
    load(a, b);
    wr(CTRL_OFS, 32'h03);
    run(0, 0);
    wr(CTRL_OFS, 32'h33);
    repeat (600) @(posedge sys_clk);
    @(negedge sys_clk);
    check("twin16 first high", 32'(a), cnt1);
    check("twin16 second high", 32'(b), cnt2);
    pc = 2'($urandom);
    dv = 1 << (2 * pc);
    b = {8'(10 + $urandom % 40), 8'(60 + $urandom % 40)};
    a = {8'(50 + $urandom % 9), 8'($urandom % 60)};
    load(a, b);
    wr(CTRL_OFS, {24'h0, 1'h0, MODE_TWIN8, pc, 2'h3});
    run(4 * dv, (b[7:0] + 1) * 2 * dv);
    check("twin8 first high", 32'(2 * dv * a[7:0]), cnt1);
    check("twin8 second high", 32'(2 * dv * (a[15:8] - b[15:8])), cnt2);
    b = {8'(10 + $urandom % 20), 8'(10 + $urandom % 20)};
    a = {8'($urandom % b[15:8]), 8'($urandom % b[7:0])};
    load(a, b);
    wr(CTRL_OFS, {24'h0, 1'h0, MODE_DUAL8, 2'h1, 2'h3});
    run(16, (b[7:0] + 1) * (b[15:8] + 1) * 4);
    check("dual8 first high", 32'(4 * a[7:0] * (b[15:8] + 1)), cnt1);
    check("dual8 second high", 32'(4 * a[15:8] * (b[7:0] + 1)), cnt2);
    b = 16'(100 + $urandom % 200);
    a = 16'($urandom % b);
    load(a, b);
    wr(CTRL_OFS, 32'h13);
    run(4, 2 * b);
    check("single first released", 32'h0, cnt1);
    check("single high", 32'(2 * a), cnt2);
    a = {8'($urandom), 8'h0};
    b = {8'($urandom), 8'h0};
    load(a, b);
    wr(CTRL_OFS, 32'h43);
    run(8, 256);
    check("nrz first high", 32'(a[15:8]), cnt1);
    check("nrz second high", 32'(b[15:8]), cnt2);
    wr(CTRL_OFS, 32'h67);
    run(16, 1024);
    check("rz first high", 32'(2 * a[15:8]), cnt1);
    check("rz second high", 32'(2 * b[15:8]), cnt2);
    give_verdict();
  end
endmodule
